// ===== rtl/dabe_exec.v
// ALU and branch execute unit with an AHB-Lite register window.
// Assumes a single AHB-Lite master issuing whole-word single transfers.
//
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module dabe_exec (
    input  wire        core_clk,
    input  wire        rst_b,
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output reg  [31:0] hrdata,
    output reg         hreadyout,
    output reg         hresp,
    output reg         halted,
    output reg  [15:0] pc_out
);
`include "dabe_map.vh"
    reg  [31:0] acc_reg [0:7];
    reg  [15:0] idx_reg [0:7];
    reg  [15:0] pc_reg;
    reg  [15:0] link_register_zero;
    reg  [15:0] index_pointer_result_zero;
    reg  [15:0] branch_tgt_reg;
    reg         branch_pend_reg;
    reg         skip_slot_reg;
    reg  [7:0]  flags_reg;
    reg         sat_reg;
    reg         irq_reg;
    reg         halt_reg;
    reg         wr_pend_reg;
    reg  [7:0]  wr_addr_reg;
    reg         issue_reg;
    reg  [31:0] instr_reg;

    wire [3:0]  opc = instr_reg[`DABE_OPC_HI:`DABE_OPC_LO];
    wire [3:0]  sub = instr_reg[`DABE_SUB_HI:`DABE_SUB_LO];
    wire [3:0]  sel1 = instr_reg[`DABE_R1_HI:`DABE_R1_LO];
    wire [3:0]  sel2 = instr_reg[`DABE_R2_HI:`DABE_R2_LO];
    wire [2:0]  dst  = instr_reg[`DABE_DST_HI:`DABE_DST_LO];
    wire [15:0] tgt  = instr_reg[`DABE_ADR_HI:`DABE_ADR_LO];
    wire [5:0]  cc   = instr_reg[`DABE_CC_HI:`DABE_CC_LO];
    wire [2:0]  vidx = instr_reg[`DABE_IDX_HI:`DABE_IDX_LO];
    wire [2:0]  vinc = instr_reg[`DABE_INC_HI:`DABE_INC_LO];

    wire [31:0] opnd1 = sel1[3] ? {16'h0000, idx_reg[sel1[2:0]]} : acc_reg[sel1[2:0]];
    wire [31:0] opnd2 = sel2[3] ? {16'h0000, idx_reg[sel2[2:0]]} : acc_reg[sel2[2:0]];

    reg  [1:0]  alu_op;
    reg         alu_en;
    reg         left_shift_op;
    wire [31:0] alu_res;
    wire        alu_v;
    wire        alu_e;
    wire        alu_c;
    wire        cond_true;

    always @* begin
        alu_op        = `DABE_ALU_ADD;
        alu_en        = 1'b1;
        left_shift_op = 1'b0;
        case (opc)
            `DABE_OP_ADD, `DABE_OP_SUM_WITH_CARRY_OP: alu_op = `DABE_ALU_ADD;
            `DABE_OP_AND: alu_op = `DABE_ALU_AND;
            `DABE_OP_UNARY: begin
                case (sub)
                    `DABE_SUB_ABS: alu_op = `DABE_ALU_ABS;
                    `DABE_SUB_ASR: alu_op = `DABE_ALU_ASR;
                    `DABE_SUB_LSL: left_shift_op = 1'b1;
                    default:       alu_en = 1'b0;
                endcase
            end
            default: alu_en = 1'b0;
        endcase
    end

    dabe_alu u_alu (
        .op             (alu_op),
        .first_operand  (left_shift_op ? opnd2 : opnd1),
        .second_operand (opnd2),
        .carry_in       (flags_reg[`DABE_F_C]),
        .use_carry      (opc == `DABE_OP_SUM_WITH_CARRY_OP),
        .sat_mode       (sat_reg),
        .result         (alu_res),
        .res_v          (alu_v),
        .res_e          (alu_e),
        .res_c          (alu_c)
    );

    dabe_cond u_cond (
        .cc        (cc),
        .flag_c    (flags_reg[`DABE_F_C]),
        .flag_e    (flags_reg[`DABE_F_E]),
        .flag_v    (flags_reg[`DABE_F_V]),
        .flag_n    (flags_reg[`DABE_F_N]),
        .flag_z    (flags_reg[`DABE_F_Z]),
        .flag_x    (flags_reg[`DABE_F_X]),
        .flag_y    (flags_reg[`DABE_F_Y]),
        .sat_mode  (sat_reg),
        .cond_true (cond_true)
    );

    wire        bus_req = hsel && hready && htrans[1];
    wire [7:0]  a8      = haddr[7:0];
    wire        exec    = issue_reg && !halt_reg;
    wire        is_ctrl = (opc == `DABE_OP_CTRL);
    reg  [31:0] rd_mux;
    integer     k;

    always @* begin
        case (a8)
            `DABE_OFF_INSTR:  rd_mux = instr_reg;
            `DABE_OFF_CTRL:   rd_mux = {30'h0000_0000, irq_reg, sat_reg};
            `DABE_OFF_STATUS: rd_mux = {22'h00_0000, skip_slot_reg, halt_reg, flags_reg};
            `DABE_OFF_PC:     rd_mux = {16'h0000, pc_reg};
            `DABE_OFF_LINK:   rd_mux = {16'h0000, link_register_zero};
            `DABE_OFF_IPR:    rd_mux = {16'h0000, index_pointer_result_zero};
            default: begin
                if (a8[7:5] == 3'h1 && a8[1:0] == 2'h0)
                    rd_mux = acc_reg[a8[4:2]];
                else if (a8[7:5] == 3'h2 && a8[1:0] == 2'h0)
                    rd_mux = {16'h0000, idx_reg[a8[4:2]]};
                else
                    rd_mux = `DABE_ZERO;
            end
        endcase
    end

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hrdata    <= `DABE_ZERO;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
            wr_pend_reg <= bus_req && hwrite;
            if (bus_req) begin
                wr_addr_reg <= a8;
                if (!hwrite)
                    hrdata <= rd_mux;
            end
        end
    end

    generate
        genvar g;
        for (g = 0; g < 8; g = g + 1) begin : g_regs
            always @(posedge core_clk or negedge rst_b) begin
                if (!rst_b) begin
                    acc_reg[g] <= `DABE_ZERO;
                    idx_reg[g] <= 16'h0000;
                end else begin
                    if (exec && alu_en && dst == g)
                        acc_reg[g] <= alu_res;
                    else if (wr_pend_reg && wr_addr_reg == (`DABE_OFF_ACC_BASE + g * 4))
                        acc_reg[g] <= hwdata;
                    if (exec && is_ctrl && sub == `DABE_CT_VEC && vidx == g)
                        idx_reg[g] <= idx_reg[g] + {13'h0000, vinc};
                    else if (wr_pend_reg && wr_addr_reg == (`DABE_OFF_IDX_BASE + g * 4))
                        idx_reg[g] <= hwdata[15:0];
                end
            end
        end
    endgenerate

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            instr_reg <= `DABE_ZERO;
            issue_reg <= 1'b0;
            sat_reg   <= 1'b0;
            irq_reg   <= 1'b0;
            halt_reg  <= 1'b0;
            flags_reg <= 8'h00;
            pc_reg    <= 16'h0000;
            link_register_zero <= 16'h0000;
            index_pointer_result_zero <= 16'h0000;
            branch_tgt_reg  <= 16'h0000;
            branch_pend_reg <= 1'b0;
            skip_slot_reg   <= 1'b0;
            halted    <= 1'b0;
            pc_out    <= 16'h0000;
        end else begin
            issue_reg <= wr_pend_reg && wr_addr_reg == `DABE_OFF_INSTR;
            irq_reg   <= 1'b0;
            if (wr_pend_reg && wr_addr_reg == `DABE_OFF_INSTR)
                instr_reg <= hwdata;
            // Software may load the program counter; an executing instruction takes priority.
            if (wr_pend_reg && wr_addr_reg == `DABE_OFF_PC)
                pc_reg <= hwdata[15:0];
            if (wr_pend_reg && wr_addr_reg == `DABE_OFF_CTRL) begin
                sat_reg <= hwdata[`DABE_CTRL_SAT];
                irq_reg <= hwdata[`DABE_CTRL_IRQ];
            end
            // halt ends on interrupt, flags untouched.
            if (irq_reg)
                halt_reg <= 1'b0;
            if (exec) begin
                if (branch_pend_reg) begin
                    pc_reg          <= branch_tgt_reg;
                    branch_pend_reg <= 1'b0;
                end else begin
                    pc_reg <= pc_reg + `DABE_PC_STEP;
                end
                skip_slot_reg <= 1'b0;
                if (alu_en && !skip_slot_reg) begin
                    flags_reg[`DABE_F_Z] <= (alu_res == `DABE_ZERO);
                    flags_reg[`DABE_F_N] <= alu_res[`DABE_MSB];
                    flags_reg[`DABE_F_V] <= alu_v;
                    flags_reg[`DABE_F_E] <= alu_e;
                    flags_reg[`DABE_F_C] <= alu_c;
                end
                if (is_ctrl) begin
                    case (sub)
                        `DABE_CT_J: begin
                            branch_tgt_reg       <= tgt;
                            branch_pend_reg      <= 1'b1;
                            flags_reg[`DABE_F_L] <= 1'b0;
                        end
                        `DABE_CT_JCC: begin
                            branch_tgt_reg       <= cond_true ? tgt : pc_reg + `DABE_LINK_STEP;
                            branch_pend_reg      <= 1'b1;
                            flags_reg[`DABE_F_L] <= 1'b0;
                        end
                        `DABE_CT_CALL: begin
                            link_register_zero   <= pc_reg + `DABE_LINK_STEP;
                            branch_tgt_reg       <= tgt;
                            branch_pend_reg      <= cond_true;
                            flags_reg[`DABE_F_L] <= 1'b0;
                        end
                        `DABE_CT_HALT: halt_reg <= ~irq_reg;
                        `DABE_CT_VEC: begin
                            pc_reg                    <= tgt;
                            skip_slot_reg             <= 1'b1;
                            index_pointer_result_zero <= 16'h0000;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            halted <= halt_reg;
            pc_out <= pc_reg;
        end
    end
endmodule // dabe_exec

// ===== rtl/dabe_map.vh
// Constants for the ALU and branch execute unit: AHB map, field positions, opcodes.
// Assumes the includer is a Verilog-2005 module using these names.
`ifndef DABE_MAP_VH
`define DABE_MAP_VH

`define DABE_DW           32
`define DABE_AW           16
`define DABE_ONE          32'h0000_0001
`define DABE_ZERO         32'h0000_0000
`define DABE_MAXPOS       32'h7fff_ffff
`define DABE_MINNEG       32'h8000_0000
`define DABE_MSB          31
`define DABE_PC_STEP      16'h0001
`define DABE_LINK_STEP    16'h0002

// Register byte offsets.
`define DABE_OFF_INSTR    8'h00
`define DABE_OFF_CTRL     8'h04
`define DABE_OFF_STATUS   8'h08
`define DABE_OFF_PC       8'h0c
`define DABE_OFF_LINK     8'h10
`define DABE_OFF_ACC_BASE 8'h20
`define DABE_OFF_IDX_BASE 8'h40
`define DABE_OFF_IPR      8'h60

// Control register bits.
`define DABE_CTRL_SAT     0
`define DABE_CTRL_IRQ     1
`define DABE_CTRL_DSLOT   2

// Flag, halt and skip bit positions in the status word.
`define DABE_F_C          0
`define DABE_F_E          1
`define DABE_F_V          2
`define DABE_F_N          3
`define DABE_F_Z          4
`define DABE_F_X          5
`define DABE_F_Y          6
`define DABE_F_L          7
`define DABE_ST_HALT      8
`define DABE_ST_SKIP      9

// Instruction fields.
`define DABE_OPC_HI       31
`define DABE_OPC_LO       28
`define DABE_SUB_HI       27
`define DABE_SUB_LO       24
`define DABE_R1_HI        23
`define DABE_R1_LO        20
`define DABE_R2_HI        19
`define DABE_R2_LO        16
`define DABE_DST_HI       15
`define DABE_DST_LO       13
`define DABE_ADR_HI       21
`define DABE_ADR_LO       6
`define DABE_CC_HI        5
`define DABE_CC_LO        0
`define DABE_IDX_HI       2
`define DABE_IDX_LO       0
`define DABE_INC_HI       5
`define DABE_INC_LO       3

// Major opcodes and sub-opcodes.
`define DABE_OP_ADD       4'h4
`define DABE_OP_SUM_WITH_CARRY_OP      4'h8
`define DABE_OP_AND       4'hb
`define DABE_OP_UNARY     4'hf
`define DABE_OP_CTRL      4'h2
`define DABE_SUB_ABS      4'h0
`define DABE_SUB_ASR      4'h1
`define DABE_SUB_LSL      4'h2
`define DABE_CT_J         4'h0
`define DABE_CT_JCC       4'h1
`define DABE_CT_CALL      4'h9
`define DABE_CT_HALT      4'h3
`define DABE_CT_VEC       4'ha

// Condition codes.
`define DABE_CC_ALWAYS    6'h00
`define DABE_CC_LT        6'h08
`define DABE_CC_LE        6'h09
`define DABE_CC_GE        6'h18
`define DABE_CC_GT        6'h19
`define DABE_CC_CLR       6'h10

// ALU selects.
`define DABE_ALU_ADD      2'h0
`define DABE_ALU_AND      2'h1
`define DABE_ALU_ABS      2'h2
`define DABE_ALU_ASR      2'h3

`endif

// ===== rtl/dabe_cond.v
// Condition-code evaluator for conditional branches.
// Assumes flags come from flip-flops on the same clock.
`timescale 1ns/1ps
module dabe_cond (
    input  wire [5:0] cc,
    input  wire       flag_c,
    input  wire       flag_e,
    input  wire       flag_v,
    input  wire       flag_n,
    input  wire       flag_z,
    input  wire       flag_x,
    input  wire       flag_y,
    input  wire       sat_mode,
    output reg        cond_true
);
`include "dabe_map.vh"
    wire [7:0] sel_flags;
    wire       below_zero_test;
    assign sel_flags = {flag_y, flag_x, flag_z, flag_n, flag_v, flag_e, flag_c, 1'b1};
    assign below_zero_test = flag_n ^ (flag_v & sat_mode);
    always @* begin
        case (cc)
            `DABE_CC_ALWAYS, 6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h07: begin
                cond_true = sel_flags[cc[2:0]];
            end
            6'h11, 6'h12, 6'h13, 6'h14, 6'h15, 6'h16, 6'h17: begin
                cond_true = ~sel_flags[cc[2:0]];
            end
            `DABE_CC_LT: cond_true = below_zero_test;
            `DABE_CC_LE: cond_true = below_zero_test | flag_z;
            `DABE_CC_GE: cond_true = ~below_zero_test;
            `DABE_CC_GT: cond_true = ~(below_zero_test | flag_z);
            default:     cond_true = 1'b0;
        endcase
    end
endmodule // dabe_cond

// ===== rtl/dabe_alu.v
// Combinational ALU: sum, sum with carry, conjunction, magnitude, arithmetic right shift.
// Assumes operands and flags are registered by the caller.
`timescale 1ns/1ps
module dabe_alu (
    input  wire [1:0]  op,
    input  wire [31:0] first_operand,
    input  wire [31:0] second_operand,
    input  wire        carry_in,
    input  wire        use_carry,
    input  wire        sat_mode,
    output reg  [31:0] result,
    output reg         res_v,
    output reg         res_e,
    output reg         res_c
);
`include "dabe_map.vh"
    reg [32:0] wide;
    reg        ovf;
    always @* begin
        wide   = 33'h0_0000_0000;
        ovf    = 1'b0;
        result = `DABE_ZERO;
        res_v  = 1'b0;
        res_e  = 1'b0;
        res_c  = 1'b0;
        case (op)
            // plain sum; sum plus carry; carry out.
            `DABE_ALU_ADD: begin
                wide   = {1'b0, first_operand} + {1'b0, second_operand}
                         + {32'h0000_0000, use_carry & carry_in};
                result = wide[31:0];
                ovf    = (first_operand[31] == second_operand[31])
                         && (wide[31] != first_operand[31]);
                res_c  = wide[32];
                res_e  = wide[32] ^ first_operand[31] ^ second_operand[31];
            end
            `DABE_ALU_AND: begin
                result = first_operand & second_operand;
                res_e  = result[`DABE_MSB];
            end
            `DABE_ALU_ABS: begin
                wide   = {1'b0, ~second_operand} + 33'h0_0000_0001;
                result = second_operand[`DABE_MSB] ? wide[31:0] : second_operand;
                ovf    = (second_operand == `DABE_MINNEG);
                res_c  = (second_operand == `DABE_ZERO);
                res_e  = second_operand[`DABE_MSB] & ~result[`DABE_MSB];
            end
            // sign kept, bit 0 into carry.
            default: begin
                result = {second_operand[`DABE_MSB], second_operand[31:1]};
                res_c  = second_operand[0];
            end
        endcase
        res_v = ovf;
        // clamp on overflow in saturation mode.
        if (ovf && sat_mode) begin
            result = (op == `DABE_ALU_ABS || !first_operand[31]) ? `DABE_MAXPOS : `DABE_MINNEG;
        end
    end
endmodule // dabe_alu

// ===== testbench/dabe_exec_checker.sv
// Bus and halt checks for the ALU and branch execute unit.
// Assumes the one slave's hreadyout is fed back as hready.
`timescale 1ns/1ps
module dabe_exec_checker (
    input wire        core_clk,
    input wire        rst_b,
    input wire        hsel,
    input wire [31:0] haddr,
    input wire [1:0]  htrans,
    input wire        hwrite,
    input wire [2:0]  hsize,
    input wire [31:0] hwdata,
    input wire        hready,
    input wire [31:0] hrdata,
    input wire        hreadyout,
    input wire        hresp,
    input wire        halted,
    input wire [15:0] pc_out
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    reg        dph;
    reg [7:0]  dadr;
    reg [31:0] wdat;
    // Marks the data phase of a write and keeps its address and data.
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            dph  <= 1'b0;
            dadr <= 8'h00;
            wdat <= 32'h0000_0000;
        end else begin
            dph  <= hsel && hready && htrans[1] && hwrite;
            dadr <= haddr[7:0];
            if (dph) begin
                wdat <= hwdata;
            end
        end
    end
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("slave gave an error response");
    ready_high_a: assert property (hreadyout == 1'b1)
        else $error("slave inserted a wait state");
    reset_state_a: assert property ($rose(rst_b) |-> pc_out == 16'h0000 && !halted)
        else $error("state after reset is wrong");
    unmapped_zero_a: assert property (hsel && hready && htrans[1] && !hwrite
        && haddr == 32'h0000_0080 |=> hrdata == 32'h0000_0000)
        else $error("unmapped read returned data");
    pc_write_a: assert property (dph && dadr == 8'h0c |=> ##[0:2] pc_out == wdat[15:0])
        else $error("program counter write not seen");
    halt_entry_a: assert property (dph && dadr == 8'h00 && hwdata[31:24] == 8'h23 |-> ##[1:5] halted)
        else $error("halt instruction did not halt");
    halt_keep_a: assert property (halted && $past(halted) |-> $stable(pc_out))
        else $error("program counter moved while halted");
    halt_wake_a: assert property (dph && dadr == 8'h04 && hwdata[1] && halted |-> ##[1:4] !halted)
        else $error("interrupt did not resume execution");
    cover property (dph && dadr == 8'h00);
    cover property ($fell(halted));
    cover property (dph && dadr == 8'h0c);
endmodule // dabe_exec_checker

bind dabe_exec dabe_exec_checker chk_i (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .halted(halted), .pc_out(pc_out));

// ===== testbench/dsp_alu_branch_execute_test.sv
// Self-checking bench for the ALU and branch execute unit.
// Assumes the unit is the only AHB-Lite slave, so hreadyout is fed back as hready.
`timescale 1ns/1ps
`include "dabe_map.vh"
module dsp_alu_branch_execute_test;
    logic        core_clk = 1'b0;
    logic        rst_b    = 1'b0;
    logic        hsel     = 1'b0;
    logic        hwrite   = 1'b0;
    logic [31:0] haddr    = 32'h0;
    logic [31:0] hwdata   = 32'h0;
    logic [1:0]  htrans   = 2'h0;
    logic [2:0]  hsize    = 3'h0;
    wire  [31:0] hrdata;
    wire         hreadyout;
    wire         hresp;
    wire         halted;
    wire  [15:0] pc_out;
    int          bad_count = 0;
    int          samples_checked = 0;
    logic [31:0] rdat;
    // Each entry: [7] branch expected taken, [6] saturation mode, [5:0] condition code.
    logic [7:0]  tab [0:16] = '{8'h80, 8'h01, 8'h83, 8'h84, 8'h05, 8'h88, 8'h89, 8'h91,
                                8'h13, 8'h14, 8'h95, 8'h18, 8'h19, 8'hc8, 8'h58, 8'h44, 8'hd4};
    dabe_exec dut (.core_clk(core_clk), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .halted(halted), .pc_out(pc_out));
    initial begin
        forever #12.5 core_clk = ~core_clk;
    end
    task summarize;
        $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task chk(input logic [31:0] s, input logic [31:0] e);
        samples_checked++;
        if (s !== e) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wrdy;
        int n;
        n = 0;
        do begin @(posedge core_clk); n++; end while (hreadyout !== 1'b1 && n < 20);
        if (hreadyout !== 1'b1) begin
            bad_count++;
            $display("[FAIL] %0t bus wait ran out", $time);
            summarize();
        end
    endtask
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        hsize <= 3'h2;
        wrdy();
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        wrdy();
        rdat = hrdata;
    endtask
    task rd(input logic [7:0] a);
        bus(1'b0, a, 32'h0);
    endtask
    task set(input logic [31:0] a0, input logic [31:0] a1);
        bus(1'b1, 8'h20, a0);
        bus(1'b1, 8'h24, a1);
    endtask
    task exec(input logic [31:0] i);
        bus(1'b1, `DABE_OFF_INSTR, i);
        repeat (2) @(posedge core_clk);
    endtask
    task wait_halt(input logic v);
        int n;
        n = 0;
        while (halted !== v && n < 20) begin @(posedge core_clk); n++; end
        if (halted !== v) begin
            bad_count++;
            $display("[FAIL] %0t halt state did not change", $time);
            summarize();
        end
    endtask
    function automatic logic [31:0] alu(input logic [3:0] o, input logic [3:0] s,
        input logic [3:0] a, input logic [3:0] b, input logic [2:0] d);
        return {o, s, a, b, d, 13'h0};
    endfunction
    function automatic logic [31:0] ctl(input logic [3:0] s, input logic [15:0] t,
        input logic [5:0] c);
        return {`DABE_OP_CTRL, s, 2'h0, t, c};
    endfunction
    task t_alu;
        set(32'h7fff_ffff, 32'h1);
        exec(alu(`DABE_OP_ADD, 4'h0, 4'h0, 4'h1, 3'h2));
        rd(8'h28); chk(rdat, 32'h8000_0000);
        rd(8'h08); chk(rdat & 32'h1d, 32'h0c);
        bus(1'b1, 8'h04, 32'h1);
        exec(alu(`DABE_OP_ADD, 4'h0, 4'h0, 4'h1, 3'h2));
        rd(8'h28); chk(rdat, 32'h7fff_ffff);
        rd(8'h08); chk(rdat & 32'h1d, 32'h04);
        bus(1'b1, 8'h04, 32'h0);
        set(32'h8000_0000, 32'h8000_0000);
        exec(alu(`DABE_OP_ADD, 4'h0, 4'h0, 4'h1, 3'h2));
        rd(8'h08); chk(rdat & 32'h1d, 32'h15);
        exec(alu(`DABE_OP_SUM_WITH_CARRY_OP, 4'h0, 4'h0, 4'h1, 3'h3));
        rd(8'h2c); chk(rdat, 32'h1);
        rd(8'h08); chk(rdat & 32'h1d, 32'h05);
        set(32'hf0f0_f0f0, 32'hff00_ff00);
        exec(alu(`DABE_OP_AND, 4'h0, 4'h0, 4'h1, 3'h2));
        rd(8'h28); chk(rdat, 32'hf000_f000);
        rd(8'h08); chk(rdat & 32'h1d, 32'h08);
        $display("alu test done");
    endtask
    task t_unary;
        set(32'h0, 32'h4000_0001);
        exec(alu(`DABE_OP_UNARY, `DABE_SUB_LSL, 4'h0, 4'h1, 3'h2));
        rd(8'h28); chk(rdat, 32'h8000_0002);
        bus(1'b1, 8'h24, 32'h8000_0003);
        exec(alu(`DABE_OP_UNARY, `DABE_SUB_ASR, 4'h0, 4'h1, 3'h3));
        rd(8'h2c); chk(rdat, 32'hc000_0001);
        rd(8'h08); chk(rdat & 32'h1, 32'h1);
        bus(1'b1, 8'h24, 32'hffff_fffb);
        exec(alu(`DABE_OP_UNARY, `DABE_SUB_ABS, 4'h0, 4'h1, 3'h2));
        rd(8'h28); chk(rdat, 32'h5);
        bus(1'b1, 8'h24, 32'h7);
        exec(alu(`DABE_OP_UNARY, `DABE_SUB_ABS, 4'h0, 4'h1, 3'h2));
        rd(8'h28); chk(rdat, 32'h7);
        bus(1'b1, 8'h04, 32'h1);
        bus(1'b1, 8'h24, `DABE_MINNEG);
        exec(alu(`DABE_OP_UNARY, `DABE_SUB_ABS, 4'h0, 4'h1, 3'h2));
        rd(8'h28); chk(rdat, `DABE_MAXPOS);
        rd(8'h08); chk(rdat & 32'h04, 32'h04);
        bus(1'b1, 8'h04, 32'h0);
        $display("unary test done");
    endtask
    task t_branch;
        bus(1'b1, 8'h0c, 32'h10);
        set(32'h2, 32'h3);
        exec(ctl(`DABE_CT_J, 16'h0100, 6'h00));
        exec(alu(`DABE_OP_ADD, 4'h0, 4'h0, 4'h1, 3'h3));
        rd(8'h0c); chk(rdat, 32'h100);
        rd(8'h2c); chk(rdat, 32'h5);
        bus(1'b1, 8'h20, 32'h4);
        exec(ctl(`DABE_CT_CALL, 16'h0200, `DABE_CC_ALWAYS));
        exec(alu(`DABE_OP_ADD, 4'h0, 4'h0, 4'h1, 3'h3));
        rd(8'h10); chk(rdat, 32'h102);
        rd(8'h0c); chk(rdat, 32'h200);
        rd(8'h2c); chk(rdat, 32'h7);
        $display("branch test done");
    endtask
    task t_vec;
        logic [31:0] s;
        rd(8'h08); s = rdat;
        bus(1'b1, 8'h48, 32'h5);
        exec(ctl(`DABE_CT_VEC, 16'h0400, 6'h1a));
        rd(8'h0c); chk(rdat, 32'h400);
        rd(8'h48); chk(rdat, 32'h8);
        rd(8'h60); chk(rdat, 32'h0);
        rd(8'h08); chk(rdat & 32'hff, s & 32'hff);
        $display("vector test done");
    endtask
    task t_halt;
        logic [31:0] s;
        logic [31:0] p;
        rd(8'h08); s = rdat;
        exec(ctl(`DABE_CT_HALT, 16'h0, 6'h00));
        wait_halt(1'b1);
        rd(8'h0c); p = rdat;
        exec(alu(`DABE_OP_ADD, 4'h0, 4'h0, 4'h1, 3'h3));
        rd(8'h0c); chk(rdat, p);
        rd(8'h08); chk(rdat & 32'hff, s & 32'hff);
        bus(1'b1, 8'h04, 32'h2);
        wait_halt(1'b0);
        chk({31'h0, halted}, 32'h0);
        $display("halt test done");
    endtask
    task t_cond;
        logic [7:0] e;
        for (int i = 0; i < 17; i++) begin
            e = tab[i];
            bus(1'b1, 8'h04, {31'h0, e[6]});
            set(32'h7fff_ffff, 32'h1);
            exec(alu(`DABE_OP_ADD, 4'h0, 4'h0, 4'h1, 3'h2));
            // flags held across the halt gap
            exec(ctl(`DABE_CT_HALT, 16'h0, 6'h00));
            wait_halt(1'b1);
            bus(1'b1, 8'h04, {30'h0, 1'b1, e[6]});
            wait_halt(1'b0);
            rd(8'h0c); e[5:0] = tab[i][5:0];
            chk_jump(rdat[15:0], e);
        end
        bus(1'b1, 8'h04, 32'h0);
        $display("condition test done");
    endtask
    task chk_jump(input logic [15:0] p, input logic [7:0] e);
        exec(ctl(`DABE_CT_JCC, 16'h0300, e[5:0]));
        exec(alu(`DABE_OP_ADD, 4'h0, 4'h0, 4'h1, 3'h3));
        rd(8'h0c); chk(rdat, e[7] ? 32'h300 : {16'h0, p + 16'h2});
    endtask
    initial begin
        repeat (5) @(posedge core_clk);
        rst_b <= 1'b1;
        @(posedge core_clk);
        chk({16'h0, pc_out}, 32'h0);
        rd(8'h80); chk(rdat, 32'h0);
        $display("reset test done");
        t_alu();
        t_unary();
        t_branch();
        t_vec();
        t_halt();
        t_cond();
        summarize();
    end
endmodule // dsp_alu_branch_execute_test
